//--- hdl/lgc_pkg.sv
// shared constants and types of the light-grid channel shift chain
`default_nettype none

package lgc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    // output stage switch-on / switch-off time, in ns (3.0 us)
    localparam int SWITCH_TIME_NS = 3000;
    localparam int SETTLE_CNT_W = 8;
    // longest time: rounds down to whole clock cycles
    localparam logic [SETTLE_CNT_W-1:0] SWITCH_CYC =
        SETTLE_CNT_W'(SWITCH_TIME_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic STAGE_RST_VAL = 1'b0;
    localparam logic OE_N_RST_VAL = 1'b1;
    localparam logic LINK_CLK_RST_VAL = 1'b0;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_RST_VAL = 8'h00;

    // ------------------------------------------------------------------
    // output stage states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OUT_OFF,
        OUT_RAMP,
        OUT_READY
    } lgc_out_state_t;

endpackage : lgc_pkg

`default_nettype wire

//--- hdl/lgc_chan_if.sv
// interface between the chain control and one three-stage channel
`timescale 1ns/1ps
`default_nettype none

interface lgc_chan_if;
    logic rise_pulse;
    logic fall_pulse;
    logic token_in;
    logic stage1;
    logic stage2;
    logic stage3;

    modport stage (
        input rise_pulse,
        input fall_pulse,
        input token_in,
        output stage1,
        output stage2,
        output stage3
    );

    modport ctrl (
        output rise_pulse,
        output fall_pulse,
        output token_in,
        input stage1,
        input stage2,
        input stage3
    );
endinterface : lgc_chan_if

`default_nettype wire

//--- hdl/lgc_channel.sv
// one channel: two rising-edge stages and one falling-edge stage
`timescale 1ns/1ps
`default_nettype none

module lgc_channel (
    input wire logic clk,
    input wire logic nrst,
    lgc_chan_if.stage chan
);
    import lgc_pkg::*;

    // ------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    wire logic stage1_next;
    wire logic stage2_next;
    wire logic stage3_next;

    // the falling-edge stage delays the token by half a link period so
    // the hand-over to the next channel cannot race the capture edge
    assign stage1_next = chan.rise_pulse ? chan.token_in : stage1_reg;
    assign stage2_next = chan.rise_pulse ? stage1_reg : stage2_reg;
    assign stage3_next = chan.fall_pulse ? stage2_reg : stage3_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= STAGE_RST_VAL;
            stage2_reg <= STAGE_RST_VAL;
            stage3_reg <= STAGE_RST_VAL;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            stage3_reg <= stage3_next;
        end
    end

    assign chan.stage1 = stage1_reg;
    assign chan.stage2 = stage2_reg;
    assign chan.stage3 = stage3_reg;

endmodule : lgc_channel

`default_nettype wire

//--- hdl/lgc_chain.sv
// top of the light-grid receiver control logic: two chained channels
// Function
// - At reset every shift stage clears; no channel active, both outputs off.
// - High serial_in wakes the amplifier on photo_input_a before capture.
// - Current outputs stay off until a rising edge captures high serial_in.
// - Low serial_in at next rising edge clears channel_a_stage1, outputs off.
// - That rising edge moves channel_a_stage1 into channel_a_stage2.
// - Falling edge loads channel_a_stage3; selects photo_input_b then.
// - Next rising edge loads channel_b_stage1; outputs enable again.
// - Second channel advances alike; its last stage drives serial_out.
// - serial_out changes only after a falling link clock edge.
// - Output stage reaches on or off state within 3.0 us.
// - Amplifier and output return to standby on fourth rising edge.
`timescale 1ns/1ps
`default_nettype none

module lgc_chain (
    input wire logic clk,
    input wire logic nrst,
    input wire logic serial_in,
    input wire logic link_clk,
    output logic serial_out,
    output logic amp_enable,
    output logic photo_input_a_sel,
    output logic photo_input_b_sel,
    output logic pos_current_out_oe_n,
    output logic neg_current_out_oe_n,
    output logic output_ready,
    output var lgc_pkg::lgc_out_state_t out_state
);
    import lgc_pkg::*;

    // ------------------------------------------------------------------
    // link clock edge detection
    // ------------------------------------------------------------------
    // the link clock is slow (10 MHz at most) against clk, so an edge is
    // a one-cycle pulse derived from the previous sample
    logic link_clk_reg;
    logic link_armed_reg;
    wire logic link_rise;
    wire logic link_fall;

    // no edge in the first cycle after reset: the link clock may already
    // stand high at release, and that level is not a rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            link_clk_reg <= LINK_CLK_RST_VAL;
            link_armed_reg <= STAGE_RST_VAL;
        end else begin
            link_clk_reg <= link_clk;
            link_armed_reg <= 1'b1;
        end
    end

    assign link_rise = link_armed_reg & link_clk & ~link_clk_reg;
    assign link_fall = link_armed_reg & ~link_clk & link_clk_reg;

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    lgc_chan_if chan_a ();
    lgc_chan_if chan_b ();

    assign chan_a.rise_pulse = link_rise;
    assign chan_a.fall_pulse = link_fall;
    assign chan_a.token_in = serial_in;
    assign chan_b.rise_pulse = link_rise;
    assign chan_b.fall_pulse = link_fall;
    assign chan_b.token_in = chan_a.stage3;

    lgc_channel u_chan_a (
        .clk(clk),
        .nrst(nrst),
        .chan(chan_a.stage)
    );

    lgc_channel u_chan_b (
        .clk(clk),
        .nrst(nrst),
        .chan(chan_b.stage)
    );

    // serial_out is the second channel's falling-edge stage itself
    assign serial_out = chan_b.stage3;

    // ------------------------------------------------------------------
    // amplifier, input selection and output stage enables
    // ------------------------------------------------------------------
    wire logic amp_next;
    wire logic out_on_next;
    wire logic sel_b_next;
    logic amp_reg;
    logic sel_a_reg;
    logic sel_b_reg;
    logic oe_n_reg;

    // the amplifier wakes on serial_in alone so it can leave standby well
    // before the capturing edge; it sleeps once the token leaves stage b1
    assign amp_next = serial_in | chan_a.stage1 | chan_a.stage2 |
                      chan_a.stage3 | chan_b.stage1;
    assign out_on_next = chan_a.stage1 | chan_b.stage1;
    // input b stays selected while stage a3 or stage b1 holds the token
    assign sel_b_next = chan_a.stage3 | chan_b.stage1;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            amp_reg <= STAGE_RST_VAL;
            sel_a_reg <= STAGE_RST_VAL;
            sel_b_reg <= STAGE_RST_VAL;
            oe_n_reg <= OE_N_RST_VAL;
        end else begin
            amp_reg <= amp_next;
            sel_a_reg <= amp_next & ~sel_b_next;
            sel_b_reg <= amp_next & sel_b_next;
            oe_n_reg <= ~out_on_next;
        end
    end

    assign amp_enable = amp_reg;
    assign photo_input_a_sel = sel_a_reg;
    assign photo_input_b_sel = sel_b_reg;
    // both low-side drivers switch together; sum current stays constant
    assign pos_current_out_oe_n = oe_n_reg;
    assign neg_current_out_oe_n = oe_n_reg;

    // ------------------------------------------------------------------
    // output stage settling
    // ------------------------------------------------------------------
    // output_ready tells the evaluator that switch-on has completed; it
    // does not cover the longer transient decay the controller waits for
    lgc_out_state_t state_reg;
    lgc_out_state_t state_next;
    logic [SETTLE_CNT_W-1:0] settle_reg;
    wire logic [SETTLE_CNT_W-1:0] settle_next;
    wire logic settle_done;
    logic ready_reg;

    assign settle_done = (settle_reg == SWITCH_CYC);
    assign settle_next = (state_reg == OUT_RAMP && !settle_done) ?
                         settle_reg + 8'h01 : SETTLE_RST_VAL;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            OUT_OFF: begin
                if (!oe_n_reg) begin
                    state_next = OUT_RAMP;
                end
            end
            OUT_RAMP: begin
                if (oe_n_reg) begin
                    state_next = OUT_OFF;
                end else if (settle_done) begin
                    state_next = OUT_READY;
                end
            end
            OUT_READY: begin
                if (oe_n_reg) begin
                    state_next = OUT_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= OUT_OFF;
            settle_reg <= SETTLE_RST_VAL;
            ready_reg <= STAGE_RST_VAL;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            ready_reg <= (state_next == OUT_READY);
        end
    end

    assign output_ready = ready_reg;
    assign out_state = state_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    localparam int SETTLE_HI = 154;

    sequence s_capture_high;
        link_rise && serial_in;
    endsequence

    sequence s_release_low;
        link_rise && !serial_in && !chan_a.stage3;
    endsequence

    sequence s_idle;
        !serial_in && !chan_a.stage1 && !chan_a.stage2 &&
        !chan_a.stage3 && !chan_b.stage1;
    endsequence

    a_idle_standby: assert property (
        s_idle |=> !amp_enable && pos_current_out_oe_n &&
            neg_current_out_oe_n)
        else $error("outputs active with no token and serial_in low");

    a_early_amp_on: assert property (
        serial_in && !chan_a.stage3 && !chan_b.stage1 |=> amp_enable &&
            photo_input_a_sel)
        else $error("serial_in high did not wake amplifier on input a");

    a_capture_on: assert property (
        s_capture_high |-> ##2 !pos_current_out_oe_n &&
            !neg_current_out_oe_n)
        else $error("captured token did not enable current outputs");

    a_release_off: assert property (
        s_release_low |=> !chan_a.stage1 ##1 pos_current_out_oe_n)
        else $error("low serial_in did not clear first stage and outputs");

    a_stage2_shift: assert property (
        link_rise |=> chan_a.stage2 == $past(chan_a.stage1))
        else $error("stage a2 did not take stage a1 on rising edge");

    a_stage3_fall: assert property (
        link_fall |=> chan_a.stage3 == $past(chan_a.stage2) ##1
            photo_input_b_sel ==
            ((chan_a.stage3 || chan_b.stage1) && amp_enable))
        else $error("stage a3 or input selection wrong after falling edge");

    a_b_capture: assert property (
        link_rise && chan_a.stage3 |=> chan_b.stage1 ##1
            !pos_current_out_oe_n)
        else $error("second channel did not take the token");

    a_dout_source: assert property (
        link_fall |=> serial_out == $past(chan_b.stage2))
        else $error("serial_out does not follow second channel");

    a_dout_fall_only: assert property (
        $changed(serial_out) |-> $past(link_fall))
        else $error("serial_out changed without a falling link edge");

    a_switch_time: assert property (
        $fell(pos_current_out_oe_n) |-> ##[1:SETTLE_HI] output_ready)
        else $error("output stage not ready within switch time");

    a_amp_standby: assert property (
        link_rise && chan_b.stage1 && !chan_a.stage3 && !chan_a.stage2 &&
            !chan_a.stage1 && !serial_in |-> ##2 !amp_enable &&
            pos_current_out_oe_n)
        else $error("amplifier not in standby after token left");

    // ------------------------------------------------------------------
    // assertions: first stages, pin levels and output stage bookkeeping
    // ------------------------------------------------------------------
    a_off_after_reset: assert property (
        !link_armed_reg |=> !chan_a.stage1 && !chan_b.stage1)
        else $error("a stage took a token in the cycle after reset");

    a_stage1_capture: assert property (
        s_capture_high |=> chan_a.stage1)
        else $error("high serial_in not captured into stage a1");

    a_amp_under_oe: assert property (
        !pos_current_out_oe_n |-> amp_enable)
        else $error("current outputs driven with amplifier in standby");

    a_sel_one_hot: assert property (
        amp_enable |-> photo_input_a_sel != photo_input_b_sel)
        else $error("not exactly one photo input selected");

    a_b_sel_hold: assert property (
        chan_b.stage1 |=> photo_input_b_sel)
        else $error("input b not selected while stage b1 holds token");

    a_standby_pins: assert property (
        !amp_enable |-> !photo_input_a_sel && !photo_input_b_sel &&
            pos_current_out_oe_n && neg_current_out_oe_n)
        else $error("standby with an input selected or outputs driven");

    a_ramp_start: assert property (
        $fell(pos_current_out_oe_n) |=> out_state == OUT_RAMP)
        else $error("output stage did not start ramping");

    a_switch_off: assert property (
        $rose(pos_current_out_oe_n) |=> !output_ready &&
            out_state == OUT_OFF)
        else $error("output stage not off after disable");

    a_dout_rise_hold: assert property (
        link_rise |=> $stable(serial_out))
        else $error("serial_out moved on a rising link edge");

    a_settle_range: assert property (
        settle_reg <= SWITCH_CYC)
        else $error("settle counter ran past the switch time");

endmodule : lgc_chain

`default_nettype wire

//--- dv/lgc_ctrl_model.sv
// controller-side model: drives the chain data input and shift clock
`timescale 1ns/1ps
`default_nettype none

module lgc_ctrl_model (
    input wire logic clk,
    output logic serial_in,
    output logic link_clk
);
    // half period of the shift clock in clk cycles: 5 MHz, under the limit
    localparam int HALF_CYC = 5;
    // data-to-capture lead: 510 cycles is 10.2 us at 50 MHz
    localparam int EN_CYC = 510;

    initial begin
        serial_in = 1'b0;
        link_clk = 1'b0;
    end

    // a high bit is followed by the amplifier wake-up wait
    task automatic put_data(input logic b);
        @(posedge clk);
        #1 serial_in = b;
        if (b) begin
            repeat (EN_CYC) @(posedge clk);
        end
    endtask : put_data

    // one shift clock edge, then hold the level for a half period
    task automatic edge_to(input logic lvl);
        @(posedge clk);
        #1 link_clk = lvl;
        repeat (HALF_CYC) @(posedge clk);
    endtask : edge_to
endmodule : lgc_ctrl_model

`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the light-grid channel shift chain
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lgc_pkg::*;
    logic clk, nrst, serial_in, link_clk, serial_out, amp_enable;
    logic sel_a, sel_b, oe_p_n, oe_m_n, output_ready;
    lgc_out_state_t out_state;
    int n_mismatch = 0;
    int tests_run = 0;

    lgc_chain i_dut (.clk(clk), .nrst(nrst), .serial_in(serial_in),
        .link_clk(link_clk), .serial_out(serial_out),
        .amp_enable(amp_enable), .photo_input_a_sel(sel_a),
        .photo_input_b_sel(sel_b), .pos_current_out_oe_n(oe_p_n),
        .neg_current_out_oe_n(oe_m_n), .output_ready(output_ready),
        .out_state(out_state));

    lgc_ctrl_model i_ctrl (.clk(clk), .serial_in(serial_in),
        .link_clk(link_clk));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input string what, input logic [1:0] seen,
                         input logic [1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // amp, sel a, sel b, both enables, serial out in one go
    task automatic outs(input logic amp, input logic sa, input logic sb,
                        input logic oen, input logic so);
        check("amp_enable", {1'b0, amp_enable}, {1'b0, amp});
        check("sel_a", {1'b0, sel_a}, {1'b0, sa});
        check("sel_b", {1'b0, sel_b}, {1'b0, sb});
        check("oe_pos", {1'b0, oe_p_n}, {1'b0, oen});
        check("oe_neg", {1'b0, oe_m_n}, {1'b0, oen});
        check("serial_out", {1'b0, serial_out}, {1'b0, so});
    endtask : outs

    // model returns on a clock edge; let that edge's updates land
    task automatic shift(input logic lvl);
        i_ctrl.edge_to(lvl);
        #2;
    endtask : shift

    task automatic ready_after_switch();
        // the evaluator keys on the rising edge of ready, so it starts low
        check("ready_low", {1'b0, output_ready}, 2'h0);
        check("ramp_state", out_state, OUT_RAMP);
        repeat (160) @(posedge clk);
        #2;
        check("output_ready", {1'b0, output_ready}, 2'h1);
        check("out_state", out_state, OUT_READY);
        repeat (90) @(posedge clk);
    endtask : ready_after_switch

    task automatic t_reset_idle();
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        check("out_state", out_state, OUT_OFF);
        repeat (2) begin
            shift(1'b1);
            shift(1'b0);
        end
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("test reset_idle done");
    endtask : t_reset_idle

    task automatic t_token();
        i_ctrl.put_data(1'b1);
        #2;
        outs(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        shift(1'b1);
        outs(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        ready_after_switch();
        i_ctrl.put_data(1'b0);
        shift(1'b0);
        shift(1'b1);
        outs(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        check("ready_off", {1'b0, output_ready}, 2'h0);
        check("state_off", out_state, OUT_OFF);
        shift(1'b0);
        outs(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        shift(1'b1);
        outs(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        ready_after_switch();
        shift(1'b0);
        outs(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        shift(1'b1);
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        shift(1'b0);
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        shift(1'b1);
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        shift(1'b0);
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("test token done");
    endtask : t_token

    // reset in mid-token must drop every stage and the output stage
    task automatic t_mid_reset();
        i_ctrl.put_data(1'b1);
        shift(1'b1);
        #1 nrst = 1'b0;
        #5;
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        i_ctrl.put_data(1'b0);
        shift(1'b0);
        outs(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        $display("test mid_reset done");
    endtask : t_mid_reset

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // the whole sequence takes about 1600 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] watchdog expected done seen timeout");
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        t_reset_idle();
        t_token();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
